// File: srt_pkg.sv
// constants, types and register map of the return / rotate execution block
// assumes a single 40 MHz clock and an apb master for all register access
package srt_pkg;
    localparam int          ADDR_W       = 8;
    localparam int          PC_W         = 21;
    localparam int          FADDR_W      = 12;
    localparam int          FLAGS_W      = 5;
    // register offsets
    localparam logic [7:0]  OFF_INSTR    = 8'h00;
    localparam logic [7:0]  OFF_CTRL     = 8'h04;
    localparam logic [7:0]  OFF_STAT     = 8'h08;
    localparam logic [7:0]  OFF_ACC      = 8'h0c;
    localparam logic [7:0]  OFF_FLAGS    = 8'h10;
    localparam logic [7:0]  OFF_BANK     = 8'h14;
    localparam logic [7:0]  OFF_PC       = 8'h18;
    localparam logic [7:0]  OFF_SHADOW   = 8'h1c;
    localparam logic [7:0]  OFF_STACK    = 8'h20;
    localparam logic [7:0]  OFF_LATCH    = 8'h24;
    localparam logic [7:0]  OFF_INDEX    = 8'h28;
    localparam logic [7:0]  OFF_FADDR    = 8'h2c;
    localparam logic [7:0]  OFF_FDATA    = 8'h30;
    // flag bit positions
    localparam int          C_BIT        = 0;
    localparam int          Z_BIT        = 2;
    localparam int          N_BIT        = 4;
    // opcode fields
    localparam logic [15:0] RET_ENC      = 16'h0012;
    localparam logic [7:0]  LITRET_HI    = 8'h0c;
    localparam logic [5:0]  ROTC_HI      = 6'h0d;
    localparam logic [7:0]  IDX_LIMIT    = 8'h5f;
    localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
    localparam logic [3:0]  ACCESS_HI    = 4'hf;
    localparam logic [1:0]  PHASE_Q4     = 2'h3;
    // reset values
    localparam logic [15:0] INSTR_RST    = 16'h0000;
    localparam logic [7:0]  BYTE_RST     = 8'h00;
    localparam logic [PC_W-1:0] PC_RST   = 21'h000000;
    localparam logic [FADDR_W-1:0] FADDR_RST = 12'h000;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} srt_state_t;

    typedef struct packed {
        logic [5:0] op;
        logic       d;
        logic       a;
        logic [7:0] f;
    } srt_instr_t;
endpackage

// File: srt_core.sv
// execution unit for subroutine return, literal return and rotate-left-through-carry
// assumes an apb master on mclk; srst synchronous active high; pready is zero-wait
`timescale 1ns/1ps
module srt_core #(
    parameter int STACK_DEPTH = 31,
    parameter int DATA_DEPTH  = 4096
) (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      srst,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [srt_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr
);
    import srt_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH + 1);

    srt_state_t           state_r;
    logic [1:0]           phase_r;
    srt_instr_t           instr_r;
    logic                 ext_en_r;
    logic [7:0]           acc_r;
    logic [FLAGS_W-1:0]   flags_r;
    logic [3:0]           bank_select_reg_r;
    logic [7:0]           accumulator_shadow_r;
    logic [FLAGS_W-1:0]   flag_shadow_r;
    logic [3:0]           bank_select_shadow_r;
    logic [PC_W-1:0]      pc_r;
    logic [7:0]           prog_counter_high_latch_r;
    logic [4:0]           prog_counter_upper_latch_r;
    logic [FADDR_W-1:0]   index_base_r;
    logic [FADDR_W-1:0]   faddr_r;
    logic [SP_W-1:0]      sp_r;
    logic [PC_W-1:0]      stack_r [STACK_DEPTH];
    logic [7:0]           general_purpose_file [DATA_DEPTH];
    logic [31:0]          prdata_r;
    logic                 pready_r;
    logic                 pslverr_r;

    // effective file address for byte-oriented operands
    function automatic logic [FADDR_W-1:0] file_addr(input logic [7:0] f, input logic a,
                                                     input logic ext, input logic [3:0] bank,
                                                     input logic [FADDR_W-1:0] idx);
        logic [FADDR_W-1:0] res;
        res = {bank, f};
        if (!a && ext && f <= IDX_LIMIT)
            res = idx + {4'h0, f};
        else if (!a)
            res = (f < ACCESS_SPLIT) ? {4'h0, f} : {ACCESS_HI, f};
        return res;
    endfunction

    // apb decode
    wire        setup    = psel & ~penable;
    wire        acc_ph   = psel & penable & pready_r;
    wire        busy     = state_r != ST_IDLE;
    wire        wr       = acc_ph & pwrite;
    wire        cpu_wr   = wr & ~busy;
    wire [7:0]  off      = paddr;
    wire        mapped   = off <= OFF_FDATA && off[1:0] == 2'h0;

    // instruction decode
    wire [15:0] iw       = instr_r;
    wire        is_ret   = iw[15:1] == RET_ENC[15:1];
    wire        is_lret  = iw[15:8] == LITRET_HI;
    wire        is_rotc  = instr_r.op == ROTC_HI;
    wire        q4       = state_r == ST_EXEC && phase_r == PHASE_Q4;
    wire        do_pop   = q4 & (is_ret | is_lret);
    wire        do_rot   = q4 & is_rotc;
    wire        restore  = do_pop & is_ret & iw[0];
    wire        stk_ne   = sp_r != '0;
    wire [SP_W-1:0]  sp_dec  = sp_r - SP_W'(1);
    wire [PC_W-1:0]  top     = stk_ne ? stack_r[sp_dec] : PC_RST;
    wire [FADDR_W-1:0] ea    = file_addr(instr_r.f, instr_r.a, ext_en_r,
                                         bank_select_reg_r, index_base_r);
    wire [7:0]  fval     = general_purpose_file[ea];
    wire [7:0]  rot      = {fval[6:0], flags_r[C_BIT]};
    wire        push     = cpu_wr && off == OFF_STACK
                           && sp_r != SP_W'(STACK_DEPTH);

    // rotate flag update: carry from old bit 7, negative and zero from result
    logic [FLAGS_W-1:0] rot_flags;
    always_comb begin
        rot_flags        = flags_r;
        rot_flags[C_BIT] = fval[7];
        rot_flags[N_BIT] = rot[7];
        rot_flags[Z_BIT] = rot == 8'h00;
    end

    // read mux
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        case (off)
            OFF_INSTR:  rdata = {16'h0000, iw};
            OFF_CTRL:   rdata = {31'h0, ext_en_r};
            OFF_STAT:   rdata = {16'h0000, 3'h0, 5'(sp_r), 7'h00, busy};
            OFF_ACC:    rdata = {24'h0, acc_r};
            OFF_FLAGS:  rdata = {27'h0, flags_r};
            OFF_BANK:   rdata = {28'h0, bank_select_reg_r};
            OFF_PC:     rdata = {11'h0, pc_r};
            OFF_SHADOW: rdata = {12'h0, bank_select_shadow_r, 3'h0, flag_shadow_r,
                                 accumulator_shadow_r};
            OFF_STACK:  rdata = {11'h0, top};
            OFF_LATCH:  rdata = {19'h0, prog_counter_upper_latch_r,
                                 prog_counter_high_latch_r};
            OFF_INDEX:  rdata = {20'h0, index_base_r};
            OFF_FADDR:  rdata = {20'h0, faddr_r};
            OFF_FDATA:  rdata = {24'h0, general_purpose_file[faddr_r]};
            default:    rdata = 32'h0000_0000;
        endcase
    end

    // apb answer, zero wait
    always_ff @(posedge mclk) begin
        if (srst) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= 1'b1;
            if (setup) begin
                prdata_r  <= mapped ? rdata : 32'h0000_0000;
                pslverr_r <= ~mapped;
            end
        end
    end

    // sequencer: one instruction cycle is four phases
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            phase_r <= 2'h0;
            instr_r <= INSTR_RST;
        end else begin
            phase_r <= busy ? phase_r + 2'h1 : 2'h0;
            case (state_r)
                ST_IDLE: begin
                    if (cpu_wr && off == OFF_INSTR) begin
                        instr_r <= pwdata[15:0];
                        state_r <= ST_EXEC;
                    end
                end
                ST_EXEC: if (q4) state_r <= (is_ret | is_lret) ? ST_NOP : ST_IDLE;
                ST_NOP:  if (phase_r == PHASE_Q4) state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // core registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            ext_en_r                   <= 1'b0;
            acc_r                      <= BYTE_RST;
            flags_r                    <= '0;
            bank_select_reg_r          <= 4'h0;
            accumulator_shadow_r       <= BYTE_RST;
            flag_shadow_r              <= '0;
            bank_select_shadow_r       <= 4'h0;
            pc_r                       <= PC_RST;
            prog_counter_high_latch_r  <= BYTE_RST;
            prog_counter_upper_latch_r <= 5'h00;
            index_base_r               <= FADDR_RST;
            faddr_r                    <= FADDR_RST;
        end else if (busy) begin
            // return leaves latches and, unless restoring, all flags alone
            if (do_pop) pc_r <= top;
            if (restore) begin
                acc_r             <= accumulator_shadow_r;
                flags_r           <= flag_shadow_r;
                bank_select_reg_r <= bank_select_shadow_r;
            end
            if (do_pop && is_lret) acc_r <= iw[7:0];
            if (do_rot) begin
                flags_r <= rot_flags;
                if (!instr_r.d) acc_r <= rot;
            end
        end else if (cpu_wr) begin
            case (off)
                OFF_CTRL:   ext_en_r <= pwdata[0];
                OFF_ACC:    acc_r <= pwdata[7:0];
                OFF_FLAGS:  flags_r <= pwdata[FLAGS_W-1:0];
                OFF_BANK:   bank_select_reg_r <= pwdata[3:0];
                OFF_PC:     pc_r <= pwdata[PC_W-1:0];
                OFF_SHADOW: begin
                    accumulator_shadow_r <= pwdata[7:0];
                    flag_shadow_r        <= pwdata[8+FLAGS_W-1:8];
                    bank_select_shadow_r <= pwdata[19:16];
                end
                OFF_LATCH: begin
                    prog_counter_high_latch_r  <= pwdata[7:0];
                    prog_counter_upper_latch_r <= pwdata[12:8];
                end
                OFF_INDEX:  index_base_r <= pwdata[FADDR_W-1:0];
                OFF_FADDR:  faddr_r <= pwdata[FADDR_W-1:0];
                default:    faddr_r <= faddr_r;
            endcase
        end
    end

    // return stack; a pop on an empty stack yields zero and keeps the pointer
    always_ff @(posedge mclk) begin
        if (srst) begin
            sp_r <= '0;
        end else if (do_pop && stk_ne) begin
            sp_r <= sp_dec;
        end else if (push) begin
            sp_r <= sp_r + SP_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (push) stack_r[sp_r] <= pwdata[PC_W-1:0];
    end

    // file memory: rotate write-back or software access
    always_ff @(posedge mclk) begin
        if (do_rot && instr_r.d)
            general_purpose_file[ea] <= rot;
        else if (cpu_wr && off == OFF_FDATA)
            general_purpose_file[faddr_r] <= pwdata[7:0];
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
endmodule

// File: srt_core_props.sv
// assertions on the apb ports of the return / rotate execution block
// assumes a bind onto srt_core, a zero-wait slave and STAT busy in bit 0
`timescale 1ns/1ps
module srt_core_props (
    // clock and reset
    input wire logic                       mclk,
    input wire logic                       srst,
    // apb
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [srt_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr
);
    import srt_pkg::*;
    logic [7:0] cnt_r;
    logic       ret_r;
    wire        acc_ev  = psel && penable && pready;
    wire        ins_wr  = acc_ev && pwrite && paddr == OFF_INSTR;
    wire        stat_rd = acc_ev && !pwrite && paddr == OFF_STAT;
    wire        is_ret  = pwdata[15:1] == RET_ENC[15:1] || pwdata[15:8] == LITRET_HI;
    wire        bad_adr = paddr[1:0] != 2'h0 || paddr > OFF_FDATA;
    // cycles since the last instruction write, and whether it was a return
    always_ff @(posedge mclk) begin
        if (srst || ins_wr) begin
            cnt_r <= 8'h00;
            ret_r <= !srst && is_ret;
        end else if (cnt_r != 8'hff) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    sequence rd_done; psel && penable && !pwrite; endsequence
    sequence stat_soon; ins_wr ##1 !psel ##1 psel && !penable ##1 stat_rd; endsequence
    a_ready_always: assert property (!$past(srst) |-> pready)
        else $error("pready low outside reset");
    a_reset_quiet: assert property (disable iff (1'b0) srst |=> !pready && !pslverr && prdata == 0)
        else $error("outputs not quiet after reset edge");
    a_unmapped_err: assert property (acc_ev && bad_adr |-> pslverr && (pwrite || prdata == 0))
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (acc_ev && !bad_adr |-> !pslverr)
        else $error("error on mapped access");
    a_rdata_holds: assert property (rd_done ##1 !psel |-> $stable(prdata))
        else $error("read data moved before next setup");
    a_busy_first: assert property (stat_soon |-> prdata[0])
        else $error("not busy right after instruction write");
    a_ret_second: assert property (stat_rd && ret_r && cnt_r inside {[5:7]} |-> prdata[0])
        else $error("return finished in one cycle");
    a_ret_ends: assert property (stat_rd && ret_r && cnt_r >= 8'h0c |-> !prdata[0])
        else $error("return still busy");
    a_rot_ends: assert property (stat_rd && !ret_r && cnt_r >= 8'h08 |-> !prdata[0])
        else $error("rotate still busy");
endmodule
bind srt_core srt_core_props u_props (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

// File: subroutine_return_and_rotate_carry_tb.sv
// self-checking bench for the return / rotate execution block
// assumes srt_core with its checker bound; this module is the apb master
`timescale 1ns/1ps
module subroutine_return_and_rotate_carry_tb;
    import srt_pkg::*;
    logic        mclk, srst, psel, penable, pwrite, pready, pslverr, err, d, a, ext;
    logic [7:0]  paddr, f, res;
    logic [11:0] ad;
    logic [31:0] pwdata, prdata, rd, top, sh, acc, flg, bk, lat, fv, idx, dep, ef;
    int          n_fail, tests_run;
    srt_core u_dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer; read data and error taken at the pready edge
    task automatic xfer(logic wr, logic [7:0] ad_i, logic [31:0] wd);
        int t;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad_i;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge mclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (t >= 50) n_fail++;
    endtask
    task automatic exec(logic [15:0] ins);
        int t;
        xfer(1'b1, OFF_INSTR, {16'h0000, ins});
        t = 0;
        do begin
            xfer(1'b0, OFF_STAT, 32'h0);
            t++;
        end while (rd[0] !== 1'b0 && t < 20);
        if (t >= 20) n_fail++;
    endtask
    function automatic logic [11:0] eaddr(logic a_i, logic e_i, logic [7:0] f_i,
                                          logic [3:0] b_i, logic [11:0] x_i);
        if (a_i) return {b_i, f_i};
        if (e_i && f_i <= IDX_LIMIT) return x_i + {4'h0, f_i};
        return f_i < ACCESS_SPLIT ? {4'h0, f_i} : {ACCESS_HI, f_i};
    endfunction
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_fail = 0;
        tests_run = 0;
        void'($urandom(32'hf0672264));
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        // return with s=0, s=1, then literal return
        for (int i = 0; i < 3; i++) begin
            {top, sh, acc, flg} = {$urandom(), $urandom(), $urandom(), $urandom()};
            {bk, lat, f} = {$urandom(), $urandom(), 8'($urandom())};
            {top, sh, acc, flg} = {top & 32'h1fffff, sh & 32'h0f1fff, acc & 32'hff, flg & 32'h1f};
            {bk, lat} = {bk & 32'hf, lat & 32'h1fff};
            xfer(1'b1, OFF_ACC, acc);
            xfer(1'b1, OFF_FLAGS, flg);
            xfer(1'b1, OFF_BANK, bk);
            xfer(1'b1, OFF_SHADOW, sh);
            xfer(1'b1, OFF_LATCH, lat);
            xfer(1'b1, OFF_STACK, ~top & 32'h1fffff);
            xfer(1'b1, OFF_STACK, top);
            xfer(1'b0, OFF_STAT, 32'h0);
            dep = (rd >> 8) & 32'h1f;
            exec(i == 2 ? {LITRET_HI, f} : RET_ENC | 16'(i));
            xfer(1'b0, OFF_PC, 32'h0);
            chk("pc", top, rd);
            xfer(1'b0, OFF_ACC, 32'h0);
            chk("acc", i == 1 ? sh & 32'hff : i == 2 ? {24'h0, f} : acc, rd);
            xfer(1'b0, OFF_FLAGS, 32'h0);
            chk("flags", i == 1 ? (sh >> 8) & 32'h1f : flg, rd);
            xfer(1'b0, OFF_BANK, 32'h0);
            chk("bank", i == 1 ? (sh >> 16) & 32'hf : bk, rd);
            xfer(1'b0, OFF_LATCH, 32'h0);
            chk("latch", lat, rd);
            xfer(1'b0, OFF_STAT, 32'h0);
            chk("depth", dep - 1, (rd >> 8) & 32'h1f);
            $display("return test %0d done", i);
        end
        // rotate: index boundary corners first, then random operands
        for (int i = 0; i < 24; i++) begin
            {d, a, ext, f} = 11'($urandom());
            {bk, idx, fv} = {$urandom(), $urandom(), $urandom()};
            {flg, acc} = {$urandom(), $urandom()};
            if (i < 4) {a, ext, d, f} = {2'b01, i[1], i[0] ? 8'h60 : IDX_LIMIT};
            {bk, idx, fv} = {bk & 32'hf, idx & 32'hfff, fv & 32'hff};
            {flg, acc} = {flg & 32'h1f, acc & 32'hff};
            ad = eaddr(a, ext, f, bk[3:0], idx[11:0]);
            res = {fv[6:0], flg[0]};
            xfer(1'b1, OFF_CTRL, {31'h0, ext});
            xfer(1'b1, OFF_BANK, bk);
            xfer(1'b1, OFF_INDEX, idx);
            xfer(1'b1, OFF_FLAGS, flg);
            xfer(1'b1, OFF_ACC, acc);
            xfer(1'b1, OFF_FADDR, {20'h0, ad});
            xfer(1'b1, OFF_FDATA, fv);
            exec({ROTC_HI, d, a, f});
            ef = {27'h0, res[7], flg[3], res == 8'h00, flg[1], fv[7]};
            xfer(1'b0, OFF_FLAGS, 32'h0);
            chk("flags", ef, rd);
            xfer(1'b0, OFF_ACC, 32'h0);
            chk("acc", d ? acc : {24'h0, res}, rd);
            xfer(1'b0, OFF_FDATA, 32'h0);
            chk("file", d ? {24'h0, res} : fv, rd);
            // rotate is idle again and leaves the stack depth alone
            xfer(1'b0, OFF_STAT, 32'h0);
            chk("stat", (dep - 1) << 8, rd);
        end
        $display("rotate test done");
        // an opcode that decodes to nothing must not pop the stack
        exec(16'hffff);
        xfer(1'b0, OFF_PC, 32'h0);
        chk("pc", top, rd);
        $display("unknown opcode test done");
        // unmapped and unaligned places are refused
        for (int k = 0; k < 3; k++) begin
            xfer(1'b0, k == 0 ? 8'h34 : k == 1 ? 8'h02 : 8'hfc, 32'h0);
            chk("err", 32'h1, {31'h0, err});
            chk("rdata", 32'h0, rd);
        end
        $display("unmapped test done");
        stop_test();
    end
    initial begin
        #500000;
        n_fail++;
        stop_test();
    end
endmodule
